// *** fidms_defs.svh ***
// Constants for the flash identification and lane-mode command logic.
// Assumes it is included by bare name from the module.
`ifndef FIDMS_DEFS_SVH
`define FIDMS_DEFS_SVH

// ****************************************
// Opcodes
// ****************************************
`define FIDMS_OP_WAKE 8'hAB
`define FIDMS_OP_SLEEP 8'hB9
`define FIDMS_OP_MD1 8'h90
`define FIDMS_OP_MD2 8'h92
`define FIDMS_OP_MD4 8'h94
`define FIDMS_OP_STD 8'h9F
`define FIDMS_OP_QON 8'h38
`define FIDMS_OP_QOFF 8'hFF

// ****************************************
// Phase lengths in received bits
// ****************************************
`define FIDMS_OPC_BITS 6'h08
`define FIDMS_ADDR_BITS 6'h18
`define FIDMS_ADDR_MODE_BITS 6'h20
`define FIDMS_LEGACY_DUMMY_BITS 6'h18
`define FIDMS_QUAD_DUMMY_BITS 6'h10
`define FIDMS_ADDR_LSB_POS 5'h08

// ****************************************
// Lane counts, byte positions, timing
// ****************************************
`define FIDMS_L1 3'h1
`define FIDMS_L2 3'h2
`define FIDMS_L4 3'h4
`define FIDMS_BYTE_BITS 4'h8
`define FIDMS_IDX_PAIR_LAST 2'h1
`define FIDMS_IDX_STD_LAST 2'h2
`define FIDMS_WAKE_REC_NS 32'h00000BB8
`define FIDMS_CLK_MHZ 32'h00000064
`define FIDMS_NS_PER_US 32'h000003E8

`endif

// *** fidms_pkg.sv ***
// Types shared by the flash identification and lane-mode logic.
// Assumes fidms_defs.svh is compiled alongside.
package fidms_pkg;
    // Command engine phases within one select frame
    typedef enum logic [2:0] {
        FIDMS_ST_OPC,
        FIDMS_ST_ADDR,
        FIDMS_ST_DUMMY,
        FIDMS_ST_OUT,
        FIDMS_ST_IGNORE
    } fidms_state_e;
    // Actions that take effect only when select rises
    typedef enum logic [2:0] {
        FIDMS_PD_NONE,
        FIDMS_PD_WAKE,
        FIDMS_PD_SLEEP,
        FIDMS_PD_QON,
        FIDMS_PD_QOFF
    } fidms_pend_e;
endpackage

// *** fidms_core.sv ***
// Command logic answering identification reads, wake and lane-mode switch.
// Assumes pins arrive asynchronously; busy and permit come from local logic.
`timescale 1ns/10ps
`default_nettype none
`include "fidms_defs.svh"

module fidms_core #(
    parameter logic [7:0] MFR_ID = 8'hA5, // Arbitrary identity value
    parameter logic [7:0] DEV_ID = 8'h5A, // Arbitrary identity value
    parameter logic [7:0] TYPE_ID = 8'h3C, // Arbitrary identity value
    parameter logic [7:0] CAP_ID = 8'hC3, // Arbitrary identity value
    parameter logic [7:0] LEGACY_ID = 8'h69, // Arbitrary identity value
    parameter int unsigned WAKE_REC_NS = `FIDMS_WAKE_REC_NS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sel_n_pin,
    input wire logic sck_pin,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic busy,
    input wire logic four_lane_permit_bit,
    output logic four_lane_command_mode,
    output logic deep_sleep,
    output logic wake_recovering
);
    // Least time, rounded up to whole cycles, never below one
    localparam int unsigned REC_CYC_RAW =
        (WAKE_REC_NS * `FIDMS_CLK_MHZ + `FIDMS_NS_PER_US - 1)
        / `FIDMS_NS_PER_US;
    localparam int unsigned REC_CYC = (REC_CYC_RAW < 1) ? 1 : REC_CYC_RAW;

    // ****************************************
    // Helpers
    // ****************************************
    // Shift a lane group into the low end of the receive register
    function automatic logic [31:0] shift_in(input logic [31:0] sr,
                                             input logic [3:0] io,
                                             input logic [2:0] ln);
        if (ln == `FIDMS_L4) begin
            shift_in = {sr[27:0], io};
        end else if (ln == `FIDMS_L2) begin
            shift_in = {sr[29:0], io[1:0]};
        end else begin
            shift_in = {sr[30:0], io[0]};
        end
    endfunction

    // Place the top bits of a byte on the lanes; single lane uses io1
    function automatic logic [3:0] put(input logic [7:0] b,
                                       input logic [2:0] ln);
        if (ln == `FIDMS_L4) begin
            put = b[7:4];
        end else if (ln == `FIDMS_L2) begin
            put = {2'h0, b[7:6]};
        end else begin
            put = {2'h0, b[7], 1'h0};
        end
    endfunction

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    logic [1:0] sel_sync_reg, sck_sync_reg;
    logic [3:0] io_s1_reg, io_s2_reg;
    logic sck_old_reg, sel_old_reg;
    // Second stage feeds edge, select and data logic; first stage stays private
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sel_sync_reg <= 2'h3;
            sck_sync_reg <= 2'h0;
            io_s1_reg <= 4'h0;
            io_s2_reg <= 4'h0;
            sck_old_reg <= 1'h0;
            sel_old_reg <= 1'h1;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], sel_n_pin};
            sck_sync_reg <= {sck_sync_reg[0], sck_pin};
            io_s1_reg <= io_in;
            io_s2_reg <= io_s1_reg;
            sck_old_reg <= sck_sync_reg[1];
            sel_old_reg <= sel_sync_reg[1];
        end
    end

    logic sel_low, sck_rise, sck_fall, sel_rise;
    // Both lines share latency, so edge order is kept
    assign sel_low = ~sel_sync_reg[1];
    assign sck_rise = sel_low & sck_sync_reg[1] & ~sck_old_reg;
    assign sck_fall = sel_low & ~sck_sync_reg[1] & sck_old_reg;
    assign sel_rise = sel_sync_reg[1] & ~sel_old_reg;

    // ****************************************
    // Command engine
    // ****************************************
    fidms_pkg::fidms_state_e state_reg;
    fidms_pkg::fidms_pend_e pend_reg;
    logic [31:0] sr_reg, sr_next;
    logic [5:0] cnt_reg, cnt_next, phase_len_reg;
    logic [7:0] cmd_reg, opc_now;
    logic [2:0] lanes_reg, out_lanes_reg;
    logic swap_reg;
    logic qpi_reg, sleep_reg;
    logic [$clog2(REC_CYC + 1)-1:0] rec_reg;
    logic in_rec;

    assign in_rec = (rec_reg != '0);
    assign sr_next = shift_in(sr_reg, io_s2_reg, lanes_reg);
    assign cnt_next = cnt_reg + {3'h0, lanes_reg};
    assign opc_now = sr_next[7:0];

    // Opcode decode, address and dummy phases, frame-end actions
    always_ff @(posedge clock) begin
        if (!rst_n || !sel_low) begin
            state_reg <= fidms_pkg::FIDMS_ST_OPC;
            cnt_reg <= 6'h0;
            sr_reg <= 32'h0;
            cmd_reg <= 8'h0;
            lanes_reg <= `FIDMS_L1;
            out_lanes_reg <= `FIDMS_L1;
            phase_len_reg <= `FIDMS_OPC_BITS;
            swap_reg <= 1'h0;
            if (!rst_n || sel_rise) begin
                pend_reg <= fidms_pkg::FIDMS_PD_NONE;
            end
            if (rst_n && qpi_reg) begin
                lanes_reg <= `FIDMS_L4; // Opcode arrives on four lanes
            end
        end else if (sck_rise) begin
            sr_reg <= sr_next;
            cnt_reg <= cnt_next;
            // Any clock after a frame-end opcode cancels its action
            pend_reg <= fidms_pkg::FIDMS_PD_NONE;
            case (state_reg)
                fidms_pkg::FIDMS_ST_OPC: begin
                    if (cnt_next == `FIDMS_OPC_BITS) begin
                        cnt_reg <= 6'h0;
                        cmd_reg <= opc_now;
                        state_reg <= fidms_pkg::FIDMS_ST_IGNORE;
                        if (sleep_reg) begin
                            // Only the wake opcode counts when asleep
                            // A running cycle blocks the wake as well
                            if (opc_now == `FIDMS_OP_WAKE && !busy) begin
                                pend_reg <= fidms_pkg::FIDMS_PD_WAKE;
                            end
                        end else if (in_rec || busy) begin
                            // Refused; a running cycle is left alone
                            state_reg <= fidms_pkg::FIDMS_ST_IGNORE;
                        end else if (opc_now == `FIDMS_OP_WAKE) begin
                            if (!qpi_reg) begin
                                state_reg <= fidms_pkg::FIDMS_ST_DUMMY;
                                phase_len_reg <= `FIDMS_LEGACY_DUMMY_BITS;
                            end
                        end else if (opc_now == `FIDMS_OP_SLEEP) begin
                            pend_reg <= fidms_pkg::FIDMS_PD_SLEEP;
                        end else if (opc_now == `FIDMS_OP_QON) begin
                            if (!qpi_reg && four_lane_permit_bit) begin
                                pend_reg <= fidms_pkg::FIDMS_PD_QON;
                            end
                        end else if (opc_now == `FIDMS_OP_QOFF) begin
                            if (qpi_reg) begin
                                pend_reg <= fidms_pkg::FIDMS_PD_QOFF;
                            end
                        end else if (opc_now == `FIDMS_OP_STD) begin
                            state_reg <= fidms_pkg::FIDMS_ST_OUT;
                            out_lanes_reg <= lanes_reg;
                        end else if (opc_now == `FIDMS_OP_MD1) begin
                            state_reg <= fidms_pkg::FIDMS_ST_ADDR;
                            phase_len_reg <= `FIDMS_ADDR_BITS;
                            out_lanes_reg <= lanes_reg;
                        end else if (opc_now == `FIDMS_OP_MD2) begin
                            state_reg <= fidms_pkg::FIDMS_ST_ADDR;
                            phase_len_reg <= `FIDMS_ADDR_MODE_BITS;
                            lanes_reg <= qpi_reg ? `FIDMS_L4 : `FIDMS_L2;
                            out_lanes_reg <= qpi_reg ? `FIDMS_L4 : `FIDMS_L2;
                        end else if (opc_now == `FIDMS_OP_MD4) begin
                            state_reg <= fidms_pkg::FIDMS_ST_ADDR;
                            phase_len_reg <= `FIDMS_ADDR_MODE_BITS;
                            lanes_reg <= `FIDMS_L4;
                            out_lanes_reg <= `FIDMS_L4;
                        end
                    end
                end
                fidms_pkg::FIDMS_ST_ADDR: begin
                    if (cnt_next == phase_len_reg) begin
                        cnt_reg <= 6'h0;
                        // Lowest address bit picks which byte leads
                        swap_reg <= (phase_len_reg == `FIDMS_ADDR_BITS) ?
                            sr_next[0] : sr_next[`FIDMS_ADDR_LSB_POS];
                        if (cmd_reg == `FIDMS_OP_MD4) begin
                            state_reg <= fidms_pkg::FIDMS_ST_DUMMY;
                            phase_len_reg <= `FIDMS_QUAD_DUMMY_BITS;
                        end else begin
                            state_reg <= fidms_pkg::FIDMS_ST_OUT;
                        end
                    end
                end
                fidms_pkg::FIDMS_ST_DUMMY: begin
                    if (cnt_next == phase_len_reg) begin
                        state_reg <= fidms_pkg::FIDMS_ST_OUT;
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // ****************************************
    // Mode, deep power-down and wake recovery
    // ****************************************
    // Only these flags change; write, suspend, wrap state lives elsewhere
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            qpi_reg <= 1'h0;
            sleep_reg <= 1'h0;
            rec_reg <= '0;
        end else begin
            if (in_rec) begin
                rec_reg <= rec_reg - 1'b1;
            end
            if (sel_rise) begin
                case (pend_reg)
                    fidms_pkg::FIDMS_PD_WAKE: begin
                        sleep_reg <= 1'h0;
                        rec_reg <= REC_CYC[$bits(rec_reg)-1:0];
                    end
                    fidms_pkg::FIDMS_PD_SLEEP: sleep_reg <= 1'h1;
                    fidms_pkg::FIDMS_PD_QON: qpi_reg <= 1'h1;
                    fidms_pkg::FIDMS_PD_QOFF: qpi_reg <= 1'h0;
                    default: qpi_reg <= qpi_reg;
                endcase
            end
        end
    end

    // ****************************************
    // Identification shifter
    // ****************************************
    logic [1:0] idx_reg;
    logic [3:0] left_reg;
    logic [7:0] osr_reg, cur_byte;
    logic [3:0] io_out_reg;

    // Byte at the current position of the repeating sequence
    always_comb begin
        if (cmd_reg == `FIDMS_OP_WAKE) begin
            cur_byte = LEGACY_ID;
        end else if (cmd_reg == `FIDMS_OP_STD) begin
            cur_byte = (idx_reg == 2'h0) ? MFR_ID :
                (idx_reg == 2'h1) ? TYPE_ID : CAP_ID;
        end else begin
            cur_byte = (idx_reg[0] ^ swap_reg) ? DEV_ID : MFR_ID;
        end
    end

    // Bits leave on clock fall, MSB first, sequence wraps forever
    always_ff @(posedge clock) begin
        if (!rst_n || state_reg != fidms_pkg::FIDMS_ST_OUT) begin
            idx_reg <= 2'h0;
            left_reg <= 4'h0;
            osr_reg <= 8'h0;
            io_out_reg <= 4'h0;
        end else if (sck_fall) begin
            if (left_reg == 4'h0) begin
                io_out_reg <= put(cur_byte, out_lanes_reg);
                osr_reg <= cur_byte << out_lanes_reg;
                left_reg <= `FIDMS_BYTE_BITS - {1'h0, out_lanes_reg};
                if ((cmd_reg == `FIDMS_OP_STD && idx_reg == `FIDMS_IDX_STD_LAST)
                    || (cmd_reg != `FIDMS_OP_STD
                    && idx_reg == `FIDMS_IDX_PAIR_LAST)) begin
                    idx_reg <= 2'h0;
                end else begin
                    idx_reg <= idx_reg + 2'h1;
                end
            end else begin
                io_out_reg <= put(osr_reg, out_lanes_reg);
                osr_reg <= osr_reg << out_lanes_reg;
                left_reg <= left_reg - {1'h0, out_lanes_reg};
            end
        end
    end

    // Drive only the lanes in use, and only while a reply runs
    assign io_out = io_out_reg;
    assign io_oe = (state_reg == fidms_pkg::FIDMS_ST_OUT && sel_low) ?
        put(8'hFF, out_lanes_reg) : 4'h0;
    assign four_lane_command_mode = qpi_reg;
    assign deep_sleep = sleep_reg;
    assign wake_recovering = in_rec;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_wake_end;
        pend_reg == fidms_pkg::FIDMS_PD_WAKE && sel_rise;
    endsequence
    sequence s_opc_done;
        state_reg == fidms_pkg::FIDMS_ST_OPC && sck_rise
            && cnt_next == `FIDMS_OPC_BITS;
    endsequence

    property p_wake;
        @(posedge clock) disable iff (!rst_n) s_wake_end |=> !sleep_reg;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missed");
    property p_rec;
        @(posedge clock) disable iff (!rst_n) s_wake_end |=> in_rec[*8];
    endproperty
    a_rec: assert property (p_rec) else $error("recovery short");
    property p_no_legacy_quad;
        @(posedge clock) disable iff (!rst_n)
            state_reg == fidms_pkg::FIDMS_ST_OUT && qpi_reg
            |-> cmd_reg != `FIDMS_OP_WAKE;
    endproperty
    a_no_legacy_quad: assert property (p_no_legacy_quad)
        else $error("legacy id in quad mode");
    property p_busy;
        @(posedge clock) disable iff (!rst_n)
            s_opc_done ##0 busy
            |=> state_reg == fidms_pkg::FIDMS_ST_IGNORE
            && pend_reg == fidms_pkg::FIDMS_PD_NONE;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not ignored");
    property p_fall_only;
        @(posedge clock) disable iff (!rst_n)
            $changed(io_out_reg) && sel_low |-> $past(sck_fall);
    endproperty
    a_fall_only: assert property (p_fall_only)
        else $error("output off fall");
    property p_permit;
        @(posedge clock) disable iff (!rst_n)
            !four_lane_permit_bit && !qpi_reg && !sel_low |=> !qpi_reg;
    endproperty
    a_permit: assert property (p_permit) else $error("mode w/o permit");
    property p_pwr_up;
        @(posedge clock) disable iff (!rst_n) $past(!rst_n) |-> !qpi_reg;
    endproperty
    a_pwr_up: assert property (p_pwr_up) else $error("not single lane");
    property p_qoff;
        @(posedge clock) disable iff (!rst_n)
            pend_reg == fidms_pkg::FIDMS_PD_QOFF && sel_rise |=> !qpi_reg;
    endproperty
    a_qoff: assert property (p_qoff) else $error("quad exit missed");
    property p_asleep;
        @(posedge clock) disable iff (!rst_n)
            s_opc_done ##0 (sleep_reg && opc_now != `FIDMS_OP_WAKE)
            |=> state_reg == fidms_pkg::FIDMS_ST_IGNORE
            && pend_reg == fidms_pkg::FIDMS_PD_NONE;
    endproperty
    a_asleep: assert property (p_asleep) else $error("asleep decode");
endmodule
`default_nettype wire

// *** fidms_host.sv ***
// Behavioural host controller: select, serial clock and data lanes.
// Assumes the system clock paces every pin change; clock mode 0.
`timescale 1ns/10ps
`default_nettype none
module fidms_host #(
    parameter int IDENT_REC_CLK = 8
) (
    input wire logic clock,
    output logic sel_n_pin,
    output logic sck_pin,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe
);
    logic oe_seen;

    // ****************************************
    // Idle pins
    // ****************************************
    // Serial clock parked low outside frames
    initial begin
        sel_n_pin = 1'b1;
        sck_pin = 1'b0;
        io_in = 4'h0;
        oe_seen = 1'b0;
    end

    // ****************************************
    // Frame tasks
    // ****************************************
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Select falls, then a settle gap before the first beat
    task automatic open_frame();
        @(posedge clock);
        sel_n_pin <= 1'b0;
        oe_seen = 1'b0;
        wait_clk(4);
    endtask

    // Clock falls before select rises so no stray rise cancels the command
    task automatic close_frame();
        sck_pin <= 1'b0;
        wait_clk(4);
        sel_n_pin <= 1'b1;
        io_in <= ~io_in;
        wait_clk(IDENT_REC_CLK);
    endtask

    // Lanes change while the clock is low, sampled when it is high
    task automatic beats(input logic [63:0] din, input int n, input int w,
                         output logic [63:0] dout);
        logic [3:0] m;
        m = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
        dout = 64'h0;
        for (int i = n - 1; i >= 0; i--) begin
            sck_pin <= 1'b0;
            io_in <= 4'(din >> (i * w)) & m;
            wait_clk(4);
            sck_pin <= 1'b1;
            wait_clk(4);
            oe_seen = oe_seen | (|io_oe);
            if (w == 1) begin
                dout = (dout << 1) | 64'(io_out[1]);
            end else begin
                dout = (dout << w) | 64'(io_out & m);
            end
        end
    endtask
endmodule
`default_nettype wire

// *** fidms_core_test.sv ***
// Self-checking bench for the identification and lane-mode logic.
// Assumes fidms_host drives the pins; busy and permit driven here.
`timescale 1ns/10ps
`default_nettype none
module fidms_core_test;
    localparam logic [7:0] MFR = 8'hA5; // Arbitrary identity value
    localparam logic [7:0] DEV = 8'h5A; // Arbitrary identity value
    localparam logic [7:0] TYP = 8'h3C; // Arbitrary identity value
    localparam logic [7:0] CAP = 8'hC3; // Arbitrary identity value
    localparam logic [7:0] LEG = 8'h69; // Arbitrary identity value
    localparam logic [63:0] PAT = 64'h5555555555555555;
    logic clock, rst_n, busy, four_lane_permit_bit;
    logic sel_n_pin, sck_pin, four_lane_command_mode, deep_sleep;
    logic wake_recovering;
    logic [3:0] io_in, io_out, io_oe;
    logic [63:0] d;
    int error_cnt = 0;
    int check_count = 0;

    // ****************************************
    // Instances and clock
    // ****************************************
    // Short wake recovery keeps the run brief: 1000 ns is 100 clocks
    fidms_core #(.MFR_ID(MFR), .DEV_ID(DEV), .TYPE_ID(TYP), .CAP_ID(CAP),
        .LEGACY_ID(LEG), .WAKE_REC_NS(1000)) fidms_core_i (
        .clock(clock), .rst_n(rst_n), .sel_n_pin(sel_n_pin),
        .sck_pin(sck_pin), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .busy(busy), .four_lane_permit_bit(four_lane_permit_bit),
        .four_lane_command_mode(four_lane_command_mode),
        .deep_sleep(deep_sleep), .wake_recovering(wake_recovering));
    fidms_host fidms_host_i (.clock(clock), .sel_n_pin(sel_n_pin),
        .sck_pin(sck_pin), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Lone opcode framed by select, single or four lanes
    task automatic lone(input logic [7:0] op, input logic quad);
        fidms_host_i.open_frame();
        fidms_host_i.beats(64'(op), quad ? 2 : 8, quad ? 4 : 1, d);
        fidms_host_i.close_frame();
    endtask

    // Opcode, n address beats of width w, dummy beats, then output beats
    task automatic ident(input logic [7:0] op, input logic [31:0] a,
                         input int n, input int w, input int dm,
                         input int o);
        fidms_host_i.open_frame();
        fidms_host_i.beats(64'(op), 8, 1, d);
        if (n > 0) fidms_host_i.beats(64'(a), n, w, d);
        if (dm > 0) fidms_host_i.beats(PAT, dm, w, d);
        fidms_host_i.beats(PAT, o, w, d);
        fidms_host_i.close_frame();
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_ids();
        ident(8'h9F, 32'h0, 0, 1, 0, 48);
        check(d, {16'h0, MFR, TYP, CAP, MFR, TYP, CAP});
        check(64'(fidms_host_i.oe_seen), 64'h1);
        check(64'(io_oe), 64'h0);
        ident(8'h90, 32'h000000, 24, 1, 0, 32);
        check(d, {32'h0, MFR, DEV, MFR, DEV});
        ident(8'h90, 32'h000001, 24, 1, 0, 32);
        check(d, {32'h0, DEV, MFR, DEV, MFR});
        ident(8'h92, 32'h00000100, 16, 2, 0, 16);
        check(d, {32'h0, DEV, MFR, DEV, MFR});
        ident(8'h94, 32'h00000000, 8, 4, 4, 8);
        check(d, {32'h0, MFR, DEV, MFR, DEV});
        ident(8'hAB, 32'h0, 24, 1, 0, 16);
        check(d, {48'h0, LEG, LEG});
        $display("Identification reads done");
    endtask

    // Sleep, refused traffic, busy-blocked wake, then wake and recovery
    task automatic t_sleep();
        lone(8'hB9, 1'b0);
        check(64'(deep_sleep), 64'h1);
        ident(8'h9F, 32'h0, 0, 1, 0, 24);
        check(64'(fidms_host_i.oe_seen), 64'h0);
        @(posedge clock);
        busy <= 1'b1;
        lone(8'hAB, 1'b0);
        check(64'(deep_sleep), 64'h1);
        busy <= 1'b0;
        lone(8'hAB, 1'b0);
        check({deep_sleep, wake_recovering}, 64'h1);
        ident(8'h9F, 32'h0, 0, 1, 0, 8);
        check(64'(fidms_host_i.oe_seen), 64'h0);
        fidms_host_i.wait_clk(100);
        check(64'(wake_recovering), 64'h0);
        ident(8'h9F, 32'h0, 0, 1, 0, 8);
        check(d, 64'(MFR));
        $display("Sleep and wake done");
    endtask

    // Permit gating, both switches and four-lane identification
    task automatic t_modes();
        lone(8'h38, 1'b0);
        check(64'(four_lane_command_mode), 64'h0);
        @(posedge clock);
        four_lane_permit_bit <= 1'b1;
        lone(8'hFF, 1'b0);
        check(64'(four_lane_command_mode), 64'h0);
        lone(8'h38, 1'b0);
        check(64'(four_lane_command_mode), 64'h1);
        fidms_host_i.open_frame();
        fidms_host_i.beats(64'h9F, 2, 4, d);
        fidms_host_i.beats(PAT, 12, 4, d);
        fidms_host_i.close_frame();
        check(d, {16'h0, MFR, TYP, CAP, MFR, TYP, CAP});
        fidms_host_i.open_frame();
        fidms_host_i.beats(64'hAB, 2, 4, d);
        fidms_host_i.beats(PAT, 12, 4, d);
        fidms_host_i.close_frame();
        check(64'(fidms_host_i.oe_seen), 64'h0);
        lone(8'hFF, 1'b1);
        check(64'(four_lane_command_mode), 64'h0);
        $display("Lane mode switching done");
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        rst_n = 1'b0;
        busy = 1'b0;
        four_lane_permit_bit = 1'b0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        check({io_oe, four_lane_command_mode, deep_sleep, wake_recovering},
              64'h0);
        $display("Reset state done");
        t_ids();
        t_sleep();
        t_modes();
        end_of_test();
    end

    // Generous bound: the scenarios need well under 15000 clocks
    initial begin
        repeat (40000) @(posedge clock);
        error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire
